// ==== design/cpll_top.sv ====
// How it works
// - output equals 24MHz times N K over M P
// - bit 31 enables PLL, feeds core clock once locked
// - bit 28 read-only lock status
// - post divider codes one, two, four
// - K is field 5:4 plus one
// - M is field 1:0 plus one
// - reset value 0x00001000, PLL disabled
// - 24MHz reference rate is a constant; only its presence is an input
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cpll_params.svh"
module cpll_top
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ref_clk_present_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic pll_enable_o,
    output logic sigma_delta_enable_o,
    output logic [31:0] pll_freq_hz_o,
    output logic core_clk_from_pll_o,
    output logic lock_o,
    output logic irq_o
);
    import cpll_pkg::*;
    localparam logic [`CPLL_CNT_W-1:0] LOCK_CYC = `CPLL_CNT_W'(`CPLL_LOCK_CYC);
    typedef struct packed
    {
        cpll_word_t ctrl;
        logic [`CPLL_EV_W-1:0] stat;
        logic [`CPLL_EV_W-1:0] mask;
        cpll_state_t st;
        logic [`CPLL_CNT_W-1:0] cnt;
        logic [31:0] rdata;
        logic slverr;
        logic ref_s1;
        logic ref_s2;
    } cpll_top_state_t;
    cpll_top_state_t s_q;
    cpll_top_state_t s_d;
    logic [31:0] freq;
    logic post_bad;
    logic access;
    logic wr;
    logic rd;
    logic hit;
    logic ev_lock;
    logic ev_unlock;
    logic [31:0] wmask;
    // frequency from the live factor fields
    cpll_ratio u_ratio
    (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .factor_n_i(s_q.ctrl[`CPLL_N_HI:`CPLL_N_LO]),
        .factor_k_i(s_q.ctrl[`CPLL_K_HI:`CPLL_K_LO]),
        .factor_m_i(s_q.ctrl[`CPLL_M_HI:`CPLL_M_LO]),
        .post_divider_select_i(s_q.ctrl[`CPLL_P_HI:`CPLL_P_LO]),
        .freq_hz_o(freq),
        .post_code_bad_o(post_bad)
    );
    // apb decode; zero wait state
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign hit = (paddr == `CPLL_OFS_CTRL) || (paddr == `CPLL_OFS_STAT)
        || (paddr == `CPLL_OFS_MASK) || (paddr == `CPLL_OFS_INFO);
    // byte lanes expanded to a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign wmask[gi*8 +: 8] = {8{pstrb[gi]}};
        end
    endgenerate
    // next state of everything
    always_comb
    begin
        s_d = s_q;
        ev_lock = 1'b0;
        ev_unlock = 1'b0;
        // reference presence crosses in through two flops
        s_d.ref_s1 = ref_clk_present_i;
        s_d.ref_s2 = s_q.ref_s1;
        // control write; reserved bits and lock never stored
        if (wr && paddr == `CPLL_OFS_CTRL)
        begin
            s_d.ctrl = (s_q.ctrl & ~(wmask & `CPLL_CTRL_WMASK))
                | (pwdata & wmask & `CPLL_CTRL_WMASK);
        end
        if (wr && paddr == `CPLL_OFS_MASK && pstrb[0])
        begin
            s_d.mask = pwdata[`CPLL_EV_W-1:0];
        end
        // lock sequencer: settle time restarts on a control change while locked
        case (s_q.st)
            CPLL_OFF:
            begin
                s_d.cnt = '0;
                if (s_q.ctrl[`CPLL_BIT_EN] && s_q.ref_s2)
                begin
                    s_d.st = CPLL_SETTLE;
                end
            end
            CPLL_SETTLE:
            begin
                if (!s_q.ctrl[`CPLL_BIT_EN] || !s_q.ref_s2)
                begin
                    s_d.st = CPLL_OFF;
                end
                else if (s_q.cnt == LOCK_CYC - 1'b1)
                begin
                    s_d.st = CPLL_LOCKED;
                    ev_lock = 1'b1;
                end
                else
                begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            CPLL_LOCKED:
            begin
                // a write of new factors or mode relocks
                if (!s_q.ctrl[`CPLL_BIT_EN] || !s_q.ref_s2 || (s_d.ctrl != s_q.ctrl))
                begin
                    s_d.st = s_q.ctrl[`CPLL_BIT_EN] ? CPLL_SETTLE : CPLL_OFF;
                    s_d.cnt = '0;
                    ev_unlock = 1'b1;
                end
            end
            default:
            begin
                s_d.st = CPLL_OFF;
            end
        endcase
        // read data; status read clears, new events win over the clear
        s_d.rdata = '0;
        s_d.slverr = 1'b0;
        if (rd && paddr == `CPLL_OFS_STAT)
        begin
            s_d.stat = '0;
        end
        s_d.stat[`CPLL_EV_LOCK] = s_d.stat[`CPLL_EV_LOCK] | ev_lock;
        s_d.stat[`CPLL_EV_UNLOCK] = s_d.stat[`CPLL_EV_UNLOCK] | ev_unlock;
        if (access && !hit)
        begin
            s_d.slverr = 1'b1;
        end
        if (rd)
        begin
            case (paddr)
                `CPLL_OFS_CTRL:
                begin
                    s_d.rdata = s_q.ctrl & `CPLL_CTRL_WMASK;
                    s_d.rdata[`CPLL_BIT_LOCK] = (s_q.st == CPLL_LOCKED);
                end
                `CPLL_OFS_STAT: s_d.rdata = 32'(s_q.stat);
                `CPLL_OFS_MASK: s_d.rdata = 32'(s_q.mask);
                `CPLL_OFS_INFO: s_d.rdata = {post_bad, freq[30:0]};
                default: s_d.rdata = '0;
            endcase
        end
    end
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s_q <= '0;
            s_q.ctrl <= `CPLL_CTRL_RESET;
            s_q.st <= CPLL_OFF;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    // apb answer, combinational handshake; read data combinational during the access
    assign pready = 1'b1;
    assign prdata = rd ? s_d.rdata : s_q.rdata;
    assign pslverr = access && !hit;
    // control outputs
    assign pll_enable_o = s_q.ctrl[`CPLL_BIT_EN];
    assign sigma_delta_enable_o = s_q.ctrl[`CPLL_BIT_SDM];
    assign pll_freq_hz_o = freq;
    assign lock_o = (s_q.st == CPLL_LOCKED);
    assign core_clk_from_pll_o = s_q.ctrl[`CPLL_BIT_EN] && lock_o;
    assign irq_o = |(s_q.stat & s_q.mask);
endmodule
`default_nettype wire

// ==== design/cpll_params.svh ====
`ifndef CPLL_PARAMS_SVH
`define CPLL_PARAMS_SVH
// register byte offsets
`define CPLL_OFS_CTRL 12'h000
`define CPLL_OFS_STAT 12'h004
`define CPLL_OFS_MASK 12'h008
`define CPLL_OFS_INFO 12'h00c
// control register layout
`define CPLL_CTRL_RESET 32'h00001000
`define CPLL_CTRL_WMASK 32'h81031f33
`define CPLL_BIT_EN 31
`define CPLL_BIT_LOCK 28
`define CPLL_BIT_SDM 24
`define CPLL_P_HI 17
`define CPLL_P_LO 16
`define CPLL_N_HI 12
`define CPLL_N_LO 8
`define CPLL_K_HI 5
`define CPLL_K_LO 4
`define CPLL_M_HI 1
`define CPLL_M_LO 0
// status bits: lock gained, lock lost
`define CPLL_EV_LOCK 0
`define CPLL_EV_UNLOCK 1
`define CPLL_EV_W 2
// reference rate and lock settling time
`define CPLL_REF_HZ 24000000
`define CPLL_CLK_HZ 50000000
`define CPLL_LOCK_US 20
`define CPLL_LOCK_CYC ((`CPLL_LOCK_US * (`CPLL_CLK_HZ / 1000000)))
`define CPLL_CNT_W 16
`endif

// ==== design/cpll_pkg.sv ====
`default_nettype none
package cpll_pkg;
    typedef enum logic [1:0]
    {
        CPLL_OFF = 2'b00,
        CPLL_SETTLE = 2'b01,
        CPLL_LOCKED = 2'b10
    } cpll_state_t;
    typedef logic [31:0] cpll_word_t;
endpackage
`default_nettype wire

// ==== design/cpll_ratio.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cpll_params.svh"
// computes output frequency from the factor fields
module cpll_ratio
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [4:0] factor_n_i,
    input wire logic [1:0] factor_k_i,
    input wire logic [1:0] factor_m_i,
    input wire logic [1:0] post_divider_select_i,
    output logic [31:0] freq_hz_o,
    output logic post_code_bad_o
);
    import cpll_pkg::*;
    typedef struct packed
    {
        logic [31:0] freq;
        logic bad;
    } cpll_ratio_state_t;
    cpll_ratio_state_t s_q;
    cpll_ratio_state_t s_d;
    logic [5:0] n_val;
    logic [2:0] k_val;
    logic [2:0] m_val;
    logic [2:0] p_val;
    logic [40:0] num;
    logic [5:0] den;
    // factor plus one, post divider decoded by code
    always_comb
    begin
        n_val = {1'b0, factor_n_i} + 6'h01;
        k_val = {1'b0, factor_k_i} + 3'h1;
        m_val = {1'b0, factor_m_i} + 3'h1;
        case (post_divider_select_i)
            2'h0: p_val = 3'h1;
            2'h1: p_val = 3'h2;
            2'h2: p_val = 3'h4;
            default: p_val = 3'h1; // undefined code, treat as /1
        endcase
        num = 41'(`CPLL_REF_HZ) * 41'(n_val) * 41'(k_val);
        den = 6'(m_val) * 6'(p_val); // widen first, 4 x 4 needs five bits
        s_d.freq = 32'(num / 41'(den));
        s_d.bad = (post_divider_select_i == 2'h3);
    end
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
    assign freq_hz_o = s_q.freq;
    assign post_code_bad_o = s_q.bad;
endmodule
`default_nettype wire

// ==== testbench/cpll_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpll_asserts
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic pll_enable_o,
    input wire logic sigma_delta_enable_o,
    input wire logic [31:0] pll_freq_hz_o,
    input wire logic core_clk_from_pll_o,
    input wire logic lock_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    logic acc, wr0;
    // full-word control writes only, so the expected value is the whole word
    assign acc = psel && penable;
    assign wr0 = acc && pwrite && paddr == 12'h000 && pstrb == 4'hf;
    // post code 11 runs undivided
    function automatic logic [31:0] hz(input logic [31:0] c);
        logic [63:0] f;
        f = 64'd24000000 * (c[12:8] + 64'h1) * (c[5:4] + 64'h1) / (c[1:0] + 64'h1);
        return 32'(f >> ((c[17:16] == 2'h3) ? 2'h0 : c[17:16]));
    endfunction
    AST_CORE_CLK: assert property (core_clk_from_pll_o == (pll_enable_o && lock_o))
        else $error("core clock select wrong");
    AST_EN_WR: assert property (wr0 |=> pll_enable_o == $past(pwdata[31]))
        else $error("enable not taken");
    AST_SDM_WR: assert property (wr0 |=> sigma_delta_enable_o == $past(pwdata[24]))
        else $error("sigma delta not taken");
    AST_FREQ: assert property (wr0 |=> ##1 pll_freq_hz_o == hz($past(pwdata, 2)))
        else $error("frequency wrong");
    AST_LOCK_OFF: assert property (!pll_enable_o [*3] |-> !lock_o)
        else $error("lock while disabled");
    AST_LOCK_RISE: assert property ($rose(lock_o) |-> $past(pll_enable_o, 8))
        else $error("lock without settling");
    AST_READ_CTRL: assert property (acc && !pwrite && paddr == 12'h000 |->
        prdata[28] == lock_o && (prdata & 32'h6efce0cc) == 32'h0)
        else $error("control readback wrong");
    AST_UNMAPPED: assert property (acc && paddr > 12'h00c |-> pslverr && pready)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (acc && paddr inside {12'h0, 12'h4, 12'h8, 12'hc} |-> !pslverr)
        else $error("mapped access refused");
    cover property ($rose(lock_o));
    cover property ($fell(lock_o) && pll_enable_o);
    cover property (acc && pslverr);
endmodule
bind cpll_top cpll_asserts u_chk (.clk_sys_i, .reset_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .pll_enable_o, .sigma_delta_enable_o,
    .pll_freq_hz_o, .core_clk_from_pll_o, .lock_o);
`default_nettype wire

// ==== testbench/cpu_pll_control_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpu_pll_control_tb;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, ref_clk_present_i = 1'b1, err;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq_o;
    logic pll_enable_o, sigma_delta_enable_o, core_clk_from_pll_o, lock_o;
    logic [11:0] paddr = 12'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] pwdata = 32'h0, prdata, pll_freq_hz_o, r;
    int num_errors = 0, n_tests = 0;
    cpll_top u_dut (.clk_sys_i, .reset_i, .ref_clk_present_i, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .pll_enable_o,
        .sigma_delta_enable_o, .pll_freq_hz_o, .core_clk_from_pll_o, .lock_o, .irq_o);
    initial forever #10 clk_sys_i = ~clk_sys_i;
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // setup, access held until pready, release after the sampling edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        @(posedge clk_sys_i);
        while (pready !== 1'b1) @(posedge clk_sys_i);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task give_verdict;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task t_reset;
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl_reset", r, 32'h00001000);
        check("enable_reset", pll_enable_o, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        check("status_reset", r, 32'h0);
    endtask
    // one row per post code, then a row that writes reserved and lock bits
    task t_freq;
        logic [31:0] c[5], rb[5], f[5];
        c = '{32'h00001000, 32'h00011f31, 32'h00021f21, 32'h01031f13, 32'h7efff0cc};
        rb = '{32'h00001000, 32'h00011f31, 32'h00021f21, 32'h01031f13, 32'h00031000};
        f = '{32'h18519600, 32'h2dc6c000, 32'h112a8800, 32'h16e36000, 32'h18519600};
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, 12'h000, c[i]);
            repeat (2) @(posedge clk_sys_i);
            check("freq", pll_freq_hz_o, f[i]);
            check("sdm", sigma_delta_enable_o, rb[i][24]);
            apb(1'b0, 12'h000, 32'h0);
            check("ctrl_rb", r, rb[i]);
            apb(1'b0, 12'h00c, 32'h0);
            check("info", r, {rb[i][17:16] == 2'h3, f[i][30:0]});
        end
    endtask
    task t_lock;
        int i;
        apb(1'b1, 12'h008, 32'h3);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b1, 12'h000, 32'h80001000);
        for (i = 0; i < 1200 && lock_o !== 1'b1; i++) @(posedge clk_sys_i);
        check("lock_time", i >= 1000 && i <= 1010, 32'h1);
        check("core_clk", core_clk_from_pll_o, 32'h1);
        check("irq_set", irq_o, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        check("ctrl_locked", r, 32'h90001000);
        apb(1'b0, 12'h004, 32'h0);
        check("status_gain", r, 32'h1);
        @(posedge clk_sys_i);
        check("irq_clear", irq_o, 32'h0);
        pstrb <= 4'h1;
        apb(1'b1, 12'h000, 32'hffffff01);
        pstrb <= 4'hf;
        apb(1'b0, 12'h000, 32'h0);
        check("strobe_lock_drop", r, 32'h80001001);
        apb(1'b0, 12'h004, 32'h0);
        check("status_loss", r, 32'h2);
        ref_clk_present_i <= 1'b0;
        apb(1'b1, 12'h000, 32'h00001000);
        apb(1'b1, 12'h000, 32'h80001000);
        repeat (1100) @(posedge clk_sys_i);
        check("no_ref_lock", lock_o, 32'h0);
        apb(1'b1, 12'h010, 32'hffffffff);
        check("unmapped_err", err, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        check("unmapped_noeff", r, 32'h80001000);
        check("core_clk_off", core_clk_from_pll_o, 32'h0);
    endtask
    initial
    begin
        #1000000;
        num_errors++;
        give_verdict;
    end
    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        t_reset;
        t_freq;
        t_lock;
        give_verdict;
    end
endmodule
`default_nettype wire
